// File: hdl/incl_cfg.svh
`ifndef INCL_CFG_SVH
`define INCL_CFG_SVH

// ****************************************************************
// register byte addresses (low byte even, high byte odd)
// ****************************************************************
`define ADDR_ACCEL_X_NULL 7'h10
`define ADDR_ACCEL_Y_NULL 7'h12
`define ADDR_INCL_X_NULL 7'h14
`define ADDR_INCL_Y_NULL 7'h16
`define ADDR_ROTATION_OFFSET_NULL 7'h18
`define ADDR_ALM1_THR 7'h20
`define ADDR_ALM2_THR 7'h22
`define ADDR_ALM1_SMPL 7'h24
`define ADDR_ALM2_SMPL 7'h26
`define ADDR_ALARM_CONTROL 7'h28
`define ADDR_DAC_CODE 7'h30
`define ADDR_STATUS 7'h3c
`define ADDR_COMMAND 7'h3e

// ****************************************************************
// writable bit masks and reset values
// ****************************************************************
`define MASK_DAC 16'h0fff
`define MASK_ACCEL_NULL 16'h0fff
`define MASK_ANGLE_NULL 16'h3fff
`define MASK_THR 16'hbfff
`define MASK_SMPL 16'h00ff
`define MASK_CTRL 16'hff37
`define MASK_STATUS 16'h032f
`define SMPL_RESET 16'h0001

// ****************************************************************
// command bits
// ****************************************************************
`define CMD_AUTONULL 0
`define CMD_RESTORE 1
`define CMD_DAC_LATCH 2
`define CMD_BACKUP 3
`define CMD_CLR_STATUS 4
`define CMD_SOFT_RESET 7

// ****************************************************************
// status bits
// ****************************************************************
`define ST_SUP_LOW 0
`define ST_SUP_HIGH 1
`define ST_BACKUP_FAIL 2
`define ST_LINK_FAIL 3
`define ST_SELFTEST 5
`define ST_ALM1 8

// ****************************************************************
// alarm control fields (alarm 2 source and rate sit one step above alarm 1, its filter bit one bit above)
// ****************************************************************
`define CTL_IND_SEL 0
`define CTL_IND_POL 1
`define CTL_IND_EN 2
`define CTL_FILT1 4
`define CTL_SRC1_LSB 8
`define CTL_RATE1 11
`define CTL_CH_STEP 4
`define THR_DIR_BIT 15
`define SRC_SUPPLY 3'h1
`define SRC_TEMP 3'h4

// ****************************************************************
// timing
// ****************************************************************
`define CLK_HZ 20000000
`define BACKUP_TIME_MS 50
`define BK_CNT_W 24

`endif

// File: hdl/incl_pkg.sv
package incl_pkg;
`include "incl_cfg.svh"

  typedef enum logic [1:0]
  {
    BK_IDLE = 2'b01,
    BK_BUSY = 2'b10
  } backup_state_t;

  // everything that is backed up and reloaded by soft reset
  typedef struct packed {
    logic [4:0][15:0] nulls;
    logic [1:0][15:0] thr;
    logic [1:0][15:0] smpl;
    logic [15:0] ctrl;
  } cfg_t;

  typedef struct packed {
    logic [15:0] prev;
    logic prev_ok;
    logic [7:0] cnt;
    logic [25:0] sum;
    logic active;
  } alarm_ch_t;

  typedef struct packed {
    logic [15:0] dac_code;
    logic [11:0] dac_latch;
    cfg_t cfg;
    cfg_t nv;
    logic [15:0] status;
    alarm_ch_t [1:0] ch;
    logic [1:0] line;
    logic [1:0] line_en;
    logic [15:0] rdata;
    backup_state_t bk;
    logic [`BK_CNT_W-1:0] bk_cnt;
    logic bk_bad;
  } state_t;

endpackage

// File: hdl/incl_regs.sv
`timescale 1ns/1ps
`include "incl_cfg.svh"
module incl_regs
#(
  parameter int BACKUP_CYCLES = `BACKUP_TIME_MS * (`CLK_HZ / 1000)
)
(
  input wire logic core_clk_i, // 20 MHz core clock
  input wire logic arst_n_i, // async reset, active low
  input wire logic [6:0] reg_addr_i, // register byte address
  input wire logic reg_wr_i, // byte write strobe
  input wire logic [7:0] reg_wdata_i, // byte write data
  input wire logic reg_rd_i, // word read strobe
  output logic [15:0] reg_rdata_o, // read data, next cycle
  input wire logic sample_tick_i, // one pulse per internal sample
  input wire logic [6:0][13:0] raw_data_i, // unfiltered outputs
  input wire logic [6:0][13:0] filt_data_i, // moving-average outputs
  input wire logic selftest_err_i, // self-test failure
  input wire logic link_err_i, // serial link failure
  input wire logic supply_high_i, // supply above upper limit
  input wire logic supply_low_i, // supply below lower limit
  output logic [11:0] dac_level_o, // latched dac code
  output logic digital_line_one_o, // indicator level, line one
  output logic digital_line_one_oe_o, // line one driven
  output logic digital_line_two_o, // indicator level, line two
  output logic digital_line_two_oe_o, // line two driven
  output logic backup_busy_o // nonvolatile backup running
);
  import incl_pkg::*;

  state_t q;
  state_t d;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // supply and temperature are unsigned 12-bit, the rest 14-bit signed
  function automatic logic signed [15:0] src_val(
    input logic [2:0] sel,
    input logic [13:0] v
  );
    if (sel == `SRC_SUPPLY || sel == `SRC_TEMP)
      src_val = {4'h0, v[11:0]};
    else
      src_val = {{2{v[13]}}, v};
  endfunction

  function automatic logic cmp_hit(
    input logic signed [25:0] x,
    input logic signed [25:0] lim,
    input logic gt
  );
    cmp_hit = gt ? (x > lim) : (x < lim);
  endfunction

  function automatic logic [8:0] eff_count(
    input logic [15:0] smpl
  );
    if (smpl[7:1] == 7'h00)
      eff_count = 9'h001;
    else
      eff_count = {1'b0, smpl[7:0]};
  endfunction

  // source codes 1..7 pick data ports 0..6; code 0 is parked on port 0
  // so a disabled alarm never indexes past the port array
  function automatic logic [2:0] src_index(
    input logic [2:0] sel
  );
    if (sel == 3'h0)
      src_index = 3'h0;
    else
      src_index = sel - 3'h1;
  endfunction

  // ****************************************************************
  // register map
  // ****************************************************************
  // each 16-bit register answers on both byte addresses of its word, except that command writes act only at the even byte
  function automatic logic [6:0] word_addr(
    input logic [6:0] a
  );
    word_addr = {a[6:1], 1'b0};
  endfunction

  function automatic logic [15:0] reg_read(
    input state_t s,
    input logic [6:0] a
  );
    unique case (word_addr(a))
      `ADDR_ACCEL_X_NULL: reg_read = s.cfg.nulls[0];
      `ADDR_ACCEL_Y_NULL: reg_read = s.cfg.nulls[1];
      `ADDR_INCL_X_NULL: reg_read = s.cfg.nulls[2];
      `ADDR_INCL_Y_NULL: reg_read = s.cfg.nulls[3];
      `ADDR_ROTATION_OFFSET_NULL: reg_read = s.cfg.nulls[4];
      `ADDR_ALM1_THR: reg_read = s.cfg.thr[0];
      `ADDR_ALM2_THR: reg_read = s.cfg.thr[1];
      `ADDR_ALM1_SMPL: reg_read = s.cfg.smpl[0];
      `ADDR_ALM2_SMPL: reg_read = s.cfg.smpl[1];
      `ADDR_ALARM_CONTROL: reg_read = s.cfg.ctrl;
      `ADDR_DAC_CODE: reg_read = s.dac_code;
      `ADDR_STATUS: reg_read = s.status;
      // command register is write only; unmapped reads give zero
      default: reg_read = 16'h0000;
    endcase
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    logic [15:0] cur_word;
    logic [15:0] wv;
    logic [7:0] cmd;
    logic [2:0] sel;
    logic [13:0] sample;
    logic signed [15:0] cur;
    logic signed [15:0] thr;
    logic [8:0] nsmp;
    logic signed [25:0] sum_n;
    logic signed [25:0] lim;
    logic act;
    logic lvl;
    d = q;
    cur_word = reg_read(q, reg_addr_i);
    wv = reg_addr_i[0] ? {reg_wdata_i, cur_word[7:0]}
                       : {cur_word[15:8], reg_wdata_i};
    cmd = 8'h00;

    // ****************************************************************
    // register writes
    // ****************************************************************
    if (reg_wr_i)
    begin
      unique case (word_addr(reg_addr_i))
        `ADDR_ACCEL_X_NULL: d.cfg.nulls[0] = wv & `MASK_ACCEL_NULL;
        `ADDR_ACCEL_Y_NULL: d.cfg.nulls[1] = wv & `MASK_ACCEL_NULL;
        `ADDR_INCL_X_NULL: d.cfg.nulls[2] = wv & `MASK_ANGLE_NULL;
        `ADDR_INCL_Y_NULL: d.cfg.nulls[3] = wv & `MASK_ANGLE_NULL;
        `ADDR_ROTATION_OFFSET_NULL: d.cfg.nulls[4] = wv & `MASK_ANGLE_NULL;
        `ADDR_ALM1_THR: d.cfg.thr[0] = wv & `MASK_THR;
        `ADDR_ALM2_THR: d.cfg.thr[1] = wv & `MASK_THR;
        `ADDR_ALM1_SMPL: d.cfg.smpl[0] = wv & `MASK_SMPL;
        `ADDR_ALM2_SMPL: d.cfg.smpl[1] = wv & `MASK_SMPL;
        `ADDR_ALARM_CONTROL: d.cfg.ctrl = wv & `MASK_CTRL;
        `ADDR_DAC_CODE: d.dac_code = wv & `MASK_DAC;
        `ADDR_COMMAND:
        begin
          if (!reg_addr_i[0])
            cmd = reg_wdata_i;
        end
        default: ;
      endcase
    end

    // ****************************************************************
    // register reads
    // ****************************************************************
    if (reg_rd_i)
    begin
      // a read sees the word as it stood before this edge
      d.rdata = cur_word;
      if (word_addr(reg_addr_i) == `ADDR_STATUS)
        d.status = 16'h0000;
    end

    // ****************************************************************
    // global commands
    // ****************************************************************
    // latch on command
    if (cmd[`CMD_DAC_LATCH])
      d.dac_latch = q.dac_code[11:0];
    if (cmd[`CMD_RESTORE])
      d.cfg.nulls = '0;
    if (cmd[`CMD_AUTONULL])
    begin
      d.cfg.nulls[0] = 16'(-$signed(raw_data_i[1])) & `MASK_ACCEL_NULL;
      d.cfg.nulls[1] = 16'(-$signed(raw_data_i[2])) & `MASK_ACCEL_NULL;
      d.cfg.nulls[2] = 16'(-$signed(raw_data_i[4])) & `MASK_ANGLE_NULL;
      d.cfg.nulls[3] = 16'(-$signed(raw_data_i[5])) & `MASK_ANGLE_NULL;
      d.cfg.nulls[4] = 16'(-$signed(raw_data_i[6])) & `MASK_ANGLE_NULL;
    end
    if (cmd[`CMD_CLR_STATUS])
      d.status = 16'h0000;

    // ****************************************************************
    // nonvolatile backup
    // ****************************************************************
    unique case (q.bk)
      BK_IDLE:
      begin
        if (cmd[`CMD_BACKUP] && !q.status[`ST_BACKUP_FAIL])
        begin
          d.bk = BK_BUSY;
          d.bk_cnt = '0;
          d.bk_bad = 1'b0;
        end
      end
      BK_BUSY:
      begin
        // a supply fault in any busy cycle spoils the whole backup
        // supply must stay in range
        d.bk_bad = q.bk_bad | supply_high_i | supply_low_i;
        d.bk_cnt = q.bk_cnt + 1'b1;
        if (q.bk_cnt == `BK_CNT_W'(BACKUP_CYCLES - 1))
        begin
          d.bk = BK_IDLE;
          if (d.bk_bad)
            d.status[`ST_BACKUP_FAIL] = 1'b1;
          else
            d.nv = q.cfg;
        end
      end
      default: d.bk = BK_IDLE;
    endcase

    // ****************************************************************
    // alarm engine
    // ****************************************************************
    for (int i = 0; i < 2; i++)
    begin
      sel = q.cfg.ctrl[`CTL_SRC1_LSB + `CTL_CH_STEP * i +: 3];
      if (q.cfg.ctrl[`CTL_FILT1 + i])
        sample = filt_data_i[src_index(sel)];
      else
        sample = raw_data_i[src_index(sel)];
      cur = src_val(sel, sample);
      thr = src_val(sel, q.cfg.thr[i][13:0]);
      nsmp = eff_count(q.cfg.smpl[i]);
      sum_n = $signed(q.ch[i].sum) + 26'(cur)
              - 26'($signed(q.ch[i].prev));
      // both factors widened first so the product keeps its top bits
      lim = 26'(thr) * $signed({17'h00000, nsmp});
      // a disabled alarm forgets its history; re-enabling starts clean
      if (sel == 3'h0)
        d.ch[i] = '0;
      else if (sample_tick_i)
      begin
        // prev is kept in both modes so rate mode starts with history
        d.ch[i].prev = cur;
        d.ch[i].prev_ok = 1'b1;
        if (!q.cfg.ctrl[`CTL_RATE1 + `CTL_CH_STEP * i])
        begin
          d.ch[i].active = cmp_hit(26'(cur), 26'(thr),
                                   q.cfg.thr[i][`THR_DIR_BIT]);
          d.ch[i].sum = '0;
          d.ch[i].cnt = '0;
        end
        else if (q.ch[i].prev_ok)
        begin
          // average of differences
          // sum > thr*n stands in for sum/n > thr, no divider needed
          if (9'(q.ch[i].cnt) + 9'h001 >= nsmp)
          begin
            d.ch[i].active = cmp_hit(sum_n, lim,
                                     q.cfg.thr[i][`THR_DIR_BIT]);
            d.ch[i].sum = '0;
            d.ch[i].cnt = '0;
          end
          else
          begin
            d.ch[i].sum = sum_n;
            d.ch[i].cnt = q.ch[i].cnt + 1'b1;
          end
        end
        if (d.ch[i].active)
          d.status[`ST_ALM1 + i] = 1'b1;
      end
    end

    // ****************************************************************
    // sample-time flags (set after the read and clear-status command clears so they win over those, but before soft reset)
    // ****************************************************************
    if (sample_tick_i)
    begin
      if (selftest_err_i)
        d.status[`ST_SELFTEST] = 1'b1;
      if (link_err_i)
        d.status[`ST_LINK_FAIL] = 1'b1;
      if (supply_high_i)
        d.status[`ST_SUP_HIGH] = 1'b1;
      if (supply_low_i)
        d.status[`ST_SUP_LOW] = 1'b1;
    end
    d.status = d.status & `MASK_STATUS;

    // ****************************************************************
    // indicator line
    // ****************************************************************
    // indicator drive
    act = d.ch[0].active | d.ch[1].active;
    lvl = q.cfg.ctrl[`CTL_IND_POL] ? act : ~act;
    // the unselected line stays undriven and low
    d.line = '0;
    d.line_en = '0;
    if (q.cfg.ctrl[`CTL_IND_EN])
    begin
      d.line[q.cfg.ctrl[`CTL_IND_SEL]] = lvl;
      d.line_en[q.cfg.ctrl[`CTL_IND_SEL]] = 1'b1;
    end

    // ****************************************************************
    // soft reset overrides everything else in the same write
    // ****************************************************************
    // reload from backup
    if (cmd[`CMD_SOFT_RESET])
    begin
      d.cfg = q.nv;
      d.dac_code = 16'h0000;
      d.dac_latch = 12'h000;
      d.status = 16'h0000;
      d.ch = '0;
      d.line = '0;
      d.line_en = '0;
      d.bk = BK_IDLE;
      d.bk_cnt = '0;
      d.bk_bad = 1'b0;
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      q <= '0;
      // backup copy starts at the live defaults, so early soft reset is safe
      q.cfg.smpl <= {2{`SMPL_RESET}};
      q.nv.smpl <= {2{`SMPL_RESET}};
      q.bk <= BK_IDLE;
    end
    else
      q <= d;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // every output is a plain copy of a state flip-flop
  assign reg_rdata_o = q.rdata;
  assign dac_level_o = q.dac_latch;
  assign digital_line_one_o = q.line[0];
  assign digital_line_one_oe_o = q.line_en[0];
  assign digital_line_two_o = q.line[1];
  assign digital_line_two_oe_o = q.line_en[1];
  assign backup_busy_o = q.bk[1];

endmodule

// File: bench/incl_regs_props.sv
`timescale 1ns/1ps
module incl_regs_props
#(
  parameter int BACKUP_CYCLES = 1000000
)
(
  input wire logic core_clk_i, // clock
  input wire logic arst_n_i, // reset, low
  input wire logic [6:0] reg_addr_i, // address
  input wire logic reg_wr_i, // write
  input wire logic [7:0] reg_wdata_i, // write byte
  input wire logic reg_rd_i, // read
  input wire logic [15:0] reg_rdata_o, // read word
  input wire logic sample_tick_i, // sample
  input wire logic [11:0] dac_level_o, // dac
  input wire logic digital_line_one_oe_o, // line one on
  input wire logic digital_line_two_oe_o, // line two on
  input wire logic backup_busy_o // busy
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  logic cmd_wr;
  logic st_rd;
  logic quiet;
  logic [31:0] busy_cnt;
  assign cmd_wr = reg_wr_i && reg_addr_i == 7'h3e;
  assign st_rd = reg_rd_i && reg_addr_i == 7'h3c;
  // a backup ending inside the window would set a flag on its own
  assign quiet = !sample_tick_i && !backup_busy_o;
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      busy_cnt <= '0;
    else if (backup_busy_o)
      busy_cnt <= busy_cnt + 32'h1;
    else
      busy_cnt <= '0;
  end
  a_rdata_holds: assert property (
    !reg_rd_i |=> $stable(reg_rdata_o)) else $error("read word moved");
  a_dac_latch_only: assert property (
    $changed(dac_level_o) |->
    $past(cmd_wr && (reg_wdata_i[2] || reg_wdata_i[7])))
    else $error("dac output moved without latch");
  a_soft_reset_clr: assert property (
    cmd_wr && reg_wdata_i[7] |=> dac_level_o == 12'h000 && !backup_busy_o)
    else $error("soft reset left state");
  a_backup_len: assert property (
    $fell(backup_busy_o) && !$past(cmd_wr && reg_wdata_i[7]) |->
    busy_cnt == BACKUP_CYCLES) else $error("backup length wrong");
  a_cmd_reads_zero: assert property (
    reg_rd_i && reg_addr_i == 7'h3e |=> reg_rdata_o == 16'h0000)
    else $error("command read not zero");
  a_status_bits: assert property (
    st_rd |=> (reg_rdata_o & 16'hfcd0) == 16'h0000)
    else $error("unused status bit set");
  a_read_clears: assert property (
    st_rd && quiet ##1 !reg_wr_i && quiet ##1 st_rd && quiet
    |=> reg_rdata_o == 16'h0000)
    else $error("status not cleared by read");
  a_one_line: assert property (
    !(digital_line_one_oe_o && digital_line_two_oe_o))
    else $error("both lines driven");
endmodule

// File: bench/incl_host.sv
`timescale 1ns/1ps
module incl_host
(
  input wire logic core_clk_i, // clock
  input wire logic [15:0] rdata_i, // read word
  input wire logic busy_i, // backup running
  output logic [6:0] addr_o, // byte address
  output logic wr_o, // write strobe
  output logic [7:0] wdata_o, // write byte
  output logic rd_o // read strobe
);
  initial
  begin
    addr_o = 7'h00;
    wr_o = 1'h0;
    wdata_o = 8'h00;
    rd_o = 1'h0;
  end
  // released lines show the inverse of the last value
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    #1;
    addr_o = a;
    wdata_o = d;
    wr_o = 1'h1;
    @(posedge core_clk_i);
    #1;
    wr_o = 1'h0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  task automatic wr16(input logic [6:0] a, input logic [15:0] d);
    wr(a, d[7:0]);
    wr(a | 7'h01, d[15:8]);
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] q);
    @(posedge core_clk_i);
    #1;
    addr_o = a;
    rd_o = 1'h1;
    @(posedge core_clk_i);
    #1;
    rd_o = 1'h0;
    addr_o = ~a;
    q = rdata_i;
  endtask
  task automatic nv_backup(output logic [15:0] st);
    logic [15:0] q;
    for (int t = 0; t < 2; t++)
    begin
      wr(7'h3e, 8'h08);
      // a backup that never ends is left to the bench watchdog
      while (busy_i !== 1'h0)
      begin
        @(posedge core_clk_i);
        #1;
      end
      rd(7'h3c, q);
      if (t == 0)
        st = q;
      if (q[2] !== 1'h1)
        break;
    end
  endtask
endmodule

// File: bench/incl_regs_tb_top.sv
`timescale 1ns/1ps
module incl_regs_tb_top;
  localparam int BACKUP_CYCLES = 16;
  logic core_clk;
  logic arst_n, wr, rd, tick, st_err, lnk_err, sup_hi, sup_lo;
  logic l1, l1_oe, l2, l2_oe, busy;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [15:0] rdata;
  logic [15:0] q;
  logic [6:0][13:0] raw;
  logic [6:0][13:0] filt;
  logic [11:0] dac;
  int n_mismatch = 0;
  int checks_done = 0;
  incl_regs #(.BACKUP_CYCLES(BACKUP_CYCLES)) u_incl_regs
  (
    .core_clk_i(core_clk), .arst_n_i(arst_n), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .sample_tick_i(tick), .raw_data_i(raw),
    .filt_data_i(filt), .selftest_err_i(st_err), .link_err_i(lnk_err),
    .supply_high_i(sup_hi), .supply_low_i(sup_lo), .dac_level_o(dac),
    .digital_line_one_o(l1), .digital_line_one_oe_o(l1_oe),
    .digital_line_two_o(l2), .digital_line_two_oe_o(l2_oe),
    .backup_busy_o(busy)
  );
  incl_host u_host
  (
    .core_clk_i(core_clk), .rdata_i(rdata), .busy_i(busy),
    .addr_o(addr), .wr_o(wr), .wdata_o(wdata), .rd_o(rd)
  );
  initial
  begin
    core_clk = 1'h0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string w, input logic [15:0] s,
    input logic [15:0] e);
    checks_done++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic rc(input string w, input logic [6:0] a,
    input logic [15:0] e);
    u_host.rd(a, q);
    check(w, q, e);
  endtask
  task automatic pulse();
    @(posedge core_clk);
    #1;
    tick = 1'h1;
    @(posedge core_clk);
    #1;
    tick = 1'h0;
  endtask
  task automatic t_reset();
    for (int i = 0; i < 10; i++)
      rc("reset zero", 7'(16 + 2 * i), 16'h0000);
    rc("unmapped", 7'h7e, 16'h0000);
    rc("smpl1", 7'h24, 16'h0001);
    rc("smpl2", 7'h26, 16'h0001);
    $display("t_reset done");
  endtask
  task automatic t_dac();
    u_host.wr16(7'h30, 16'hfabc);
    check("dac early", {4'h0, dac}, 16'h0000);
    rc("dac code", 7'h30, 16'h0abc);
    u_host.wr(7'h3e, 8'h00);
    check("dac zero cmd", {4'h0, dac}, 16'h0000);
    u_host.wr(7'h3e, 8'h04);
    check("dac latch", {4'h0, dac}, 16'h0abc);
    $display("t_dac done");
  endtask
  task automatic t_null();
    for (int i = 0; i < 5; i++)
    begin
      u_host.wr16(7'(16 + 2 * i), 16'hffff);
      rc("null mask", 7'(16 + 2 * i), i < 2 ? 16'h0fff : 16'h3fff);
    end
    u_host.wr(7'h3e, 8'h02);
    for (int i = 0; i < 5; i++)
      rc("restore", 7'(16 + 2 * i), 16'h0000);
    raw[1] = 14'h0005;
    raw[4] = 14'h3ff0;
    u_host.wr(7'h3e, 8'h01);
    rc("autonull acc", 7'h10, 16'h0ffb);
    rc("autonull incl", 7'h14, 16'h0010);
    $display("t_null done");
  endtask
  task automatic t_status();
    st_err = 1'h1;
    lnk_err = 1'h1;
    sup_hi = 1'h1;
    pulse();
    st_err = 1'h0;
    lnk_err = 1'h0;
    sup_hi = 1'h0;
    sup_lo = 1'h1;
    rc("status map", 7'h3c, 16'h002a);
    pulse();
    sup_lo = 1'h0;
    rc("status low", 7'h3c, 16'h0001);
    rc("status read", 7'h3c, 16'h0000);
    st_err = 1'h1;
    pulse();
    st_err = 1'h0;
    u_host.wr(7'h3e, 8'h10);
    rc("status cmd", 7'h3c, 16'h0000);
    $display("t_status done");
  endtask
  task automatic t_backup();
    u_host.wr16(7'h20, 16'h1234);
    u_host.nv_backup(q);
    check("backup ok", q, 16'h0000);
    u_host.wr16(7'h20, 16'h0000);
    u_host.wr16(7'h30, 16'h0123);
    u_host.wr(7'h3e, 8'h80);
    rc("reload", 7'h20, 16'h1234);
    rc("dac volatile", 7'h30, 16'h0000);
    sup_lo = 1'h1;
    u_host.nv_backup(q);
    check("backup fail", q, 16'h0004);
    u_host.wr(7'h3e, 8'h08);
    repeat (BACKUP_CYCLES + 2) @(posedge core_clk);
    u_host.wr(7'h3e, 8'h08);
    check("blocked", {15'h0000, busy}, 16'h0000);
    sup_lo = 1'h0;
    rc("fail flag", 7'h3c, 16'h0004);
    rc("fail cleared", 7'h3c, 16'h0000);
    $display("t_backup done");
  endtask
  task automatic t_alarm();
    raw = {7{14'h0005}};
    u_host.wr16(7'h20, 16'h8001);
    for (int s = 1; s < 8; s++)
    begin
      u_host.wr16(7'h28, 16'(s << 8) | 16'h0006);
      pulse();
      rc("alarm source", 7'h3c, 16'h0100);
      check("ind on", {12'h000, l2_oe, l2, l1_oe, l1}, 16'h0003);
    end
    u_host.wr16(7'h28, 16'h0216);
    pulse();
    rc("filtered", 7'h3c, 16'h0000);
    check("ind off", {12'h000, l2_oe, l2, l1_oe, l1}, 16'h0002);
    u_host.wr16(7'h22, 16'h0009);
    u_host.wr16(7'h28, 16'h2005);
    pulse();
    rc("less than", 7'h3c, 16'h0200);
    check("ind low", {12'h000, l2_oe, l2, l1_oe, l1}, 16'h0008);
    $display("t_alarm done");
  endtask
  task automatic t_rate();
    u_host.wr16(7'h28, 16'h0000);
    u_host.wr16(7'h24, 16'h0002);
    u_host.wr16(7'h20, 16'h8003);
    raw[1] = 14'h0000;
    u_host.wr16(7'h28, 16'h0a00);
    pulse();
    raw[1] = 14'h0004;
    pulse();
    rc("rate early", 7'h3c, 16'h0000);
    raw[1] = 14'h0008;
    pulse();
    rc("rate hit", 7'h3c, 16'h0100);
    u_host.wr16(7'h26, 16'h0000);
    filt[2] = 14'h0000;
    u_host.wr16(7'h28, 16'hb020);
    pulse();
    filt[2] = 14'h0014;
    pulse();
    rc("rate2 early", 7'h3c, 16'h0000);
    filt[2] = 14'h0019;
    pulse();
    rc("rate2 hit", 7'h3c, 16'h0200);
    $display("t_rate done");
  endtask
  initial
  begin
    #400000;
    n_mismatch++;
    close_out();
  end
  initial
  begin
    arst_n = 1'h0;
    tick = 1'h0;
    raw = '0;
    filt = '0;
    st_err = 1'h0;
    lnk_err = 1'h0;
    sup_hi = 1'h0;
    sup_lo = 1'h0;
    repeat (2) @(posedge core_clk);
    #1;
    arst_n = 1'h1;
    t_reset();
    t_dac();
    t_null();
    t_status();
    t_backup();
    t_alarm();
    t_rate();
    close_out();
  end
endmodule
bind incl_regs incl_regs_props #(.BACKUP_CYCLES(BACKUP_CYCLES)) u_props
(
  .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .sample_tick_i(sample_tick_i),
  .dac_level_o(dac_level_o), .backup_busy_o(backup_busy_o),
  .digital_line_one_oe_o(digital_line_one_oe_o),
  .digital_line_two_oe_o(digital_line_two_oe_o)
);
